// File: rtl/msee_unit.sv
// machine state word and exception enable logic with apb register access
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
// Function
// - privilege bit one allows user instructions only
// - float bit clear blocks all float dispatch
// - machine check gate enables machine checks
// - machine check while gated off enters checkstop
// - single step traps after next completion
// - branch trace traps after each branch
// - vector prefix selects 0x000 or 0xFFF base
// - fetch translate bit enables instruction translation
// - data translate bit enables data translation
// - recoverable flag marks reset/check recoverability
// - byte order bit selects little endian
// - float mode pair encodes four modes
// - float exceptions ignored when both modes zero
// - async interrupts deferred while gate clear
// - any exception clears async interrupt gate
// - save copy written before first handler instruction
// - each machine check source separately enabled
// - system reset exception masked only while in checkstop
// - reserved bits 24, 28-29 stored and saved
// - save copy takes bits 5-9, 16-31
// - every exception clears both translate bits
module msee_unit
   import msee_pkg::*;
(
   input  wire logic                   sys_clk,        // core clock
   input  wire logic                   rst_b,          // async reset, active low
   input  wire logic                   psel,           // apb select
   input  wire logic                   penable,        // apb access phase
   input  wire logic                   pwrite,         // apb direction
   input  wire logic [11:0]            paddr,          // apb byte address
   input  wire logic [31:0]            pwdata,         // apb write data
   output logic                        pready,         // apb ready
   output logic [31:0]                 prdata,         // apb read data
   output logic                        pslverr,        // apb error
   input  wire logic                   resetReq,       // system reset request level
   input  wire logic [MSEE_NUM_MC-1:0] machineCheckReq, // machine check sources
   input  wire logic                   externalReq,    // external interrupt level
   input  wire logic                   sysMgmtReq,     // system management level
   input  wire logic                   decrementerReq, // decrementer level
   input  wire logic                   floatExcReq,    // float enabled exception pulse
   input  wire msee_retire_s           retire,         // completion report
   output msee_take_s                  takeOut,        // exception taken report
   output logic                        userOnly,       // supervisor ops barred
   output logic                        floatBlocked,   // float dispatch stalled
   output logic                        fetchXlate,     // instruction translation on
   output logic                        dataXlate,      // data translation on
   output logic                        littleEndian,   // byte order
   output logic                        checkstop       // machine halted
);
   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [31:0]             stateReg;      // machine_state_word
   logic [31:0]             savedReg;      // saved_state_copy
   logic [31:0]             implReg;       // implementation_control
   logic [31:0]             infoReg;       // exception-specific save bits
   logic [19:0]             offsetReg;     // vector offset for next exception
   logic [MSEE_EV_NUM-1:0]  swEventReg;    // software-raised event pulses
   logic                    stopReg;       // checkstop latch
   logic                    traceReg;      // trace pending
   logic                    fpxReg;        // float exception pending
   msee_take_s              takeReg;       // taken report
   logic [31:0]             prdataReg;     // read data
   logic                    retReq;        // return-from-handler write

   // ---------------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------------
   // one-cycle access: pready high in every access phase
   function automatic logic msee_hit(input logic [11:0] a, input logic [11:0] off);
      msee_hit = (a == off);
   endfunction

   logic wrEn;   // write takes effect
   logic rdEn;   // read data is taken
   logic mapped; // address is one of ours
   assign wrEn   = psel && penable && pwrite;
   assign rdEn   = psel && penable && !pwrite;
   assign mapped = msee_hit(paddr, MSEE_OFF_STATE) || msee_hit(paddr, MSEE_OFF_SAVED)
                || msee_hit(paddr, MSEE_OFF_IMPL) || msee_hit(paddr, MSEE_OFF_STATUS)
                || msee_hit(paddr, MSEE_OFF_EVENT) || msee_hit(paddr, MSEE_OFF_RETURN)
                || msee_hit(paddr, MSEE_OFF_INFO) || msee_hit(paddr, MSEE_OFF_OFFSET);
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;  // unmapped answers with an error
   assign prdata  = prdataReg;
   assign retReq  = wrEn && msee_hit(paddr, MSEE_OFF_RETURN);

   // ---------------------------------------------------------------
   // exception arbitration
   // ---------------------------------------------------------------
   logic [MSEE_NUM_MC-1:0] mcLive;    // enabled machine check sources
   logic mcAny;                       // any enabled source active
   logic asyncOk;                     // asynchronous interrupts may be taken
   logic floatMode;                   // float exceptions enabled
   msee_kind_e kindNow;               // winning exception this cycle

   // each source is gated by its own implementation control bit
   genvar g;
   generate
      for (g = 0; g < MSEE_NUM_MC; g++) begin : g_mc
         assign mcLive[g] = machineCheckReq[g] && implReg[g];
      end
   endgenerate
   assign mcAny     = (|mcLive) || swEventReg[MSEE_EV_MCHK];
   assign asyncOk   = stateReg[MSEE_B_EE];
   assign floatMode = stateReg[MSEE_B_FE0] || stateReg[MSEE_B_FE1];

   // priority: reset, machine check, program, trace, external, smi, decrementer;
   // asynchronous requests are levels, so while the gate is clear they simply wait
   always_comb begin
      kindNow = MSEE_K_NONE;
      if (stopReg) begin
         kindNow = MSEE_K_NONE;                          // halted, nothing taken
      end else if (resetReq || swEventReg[MSEE_EV_RESET]) begin
         kindNow = MSEE_K_RESET;
      end else if (mcAny && stateReg[MSEE_B_ME]) begin
         kindNow = MSEE_K_MCHK;
      end else if (fpxReg) begin
         kindNow = MSEE_K_PROG;
      end else if (traceReg) begin
         kindNow = MSEE_K_TRACE;
      end else if (asyncOk && (externalReq || swEventReg[MSEE_EV_EXT])) begin
         kindNow = MSEE_K_EXT;
      end else if (asyncOk && (sysMgmtReq || swEventReg[MSEE_EV_SMI])) begin
         kindNow = MSEE_K_SMI;
      end else if (asyncOk && (decrementerReq || swEventReg[MSEE_EV_DEC])) begin
         kindNow = MSEE_K_DEC;
      end
   end

   // ---------------------------------------------------------------
   // checkstop
   // ---------------------------------------------------------------
   // only a hardware reset leaves checkstop; a system reset exception cannot
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         stopReg <= 1'b0;
      end else if (mcAny && !stateReg[MSEE_B_ME] && kindNow != MSEE_K_RESET) begin
         stopReg <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // trace pending
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         traceReg <= 1'b0;
      end else if (retire.valid && (stateReg[MSEE_B_SE]
                   || (stateReg[MSEE_B_BE] && retire.isBranch))) begin
         traceReg <= 1'b1;
      end else if (kindNow == MSEE_K_TRACE || kindNow == MSEE_K_RESET) begin
         traceReg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // float enabled exception pending
   // ---------------------------------------------------------------
   // a new report wins over the clear of the one being taken
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         fpxReg <= 1'b0;
      end else if ((floatExcReq || swEventReg[MSEE_EV_FPX]) && floatMode
                   && stateReg[MSEE_B_FP]) begin
         fpxReg <= 1'b1;
      end else if (kindNow == MSEE_K_PROG || kindNow == MSEE_K_RESET) begin
         fpxReg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // machine state word
   // ---------------------------------------------------------------
   // an exception outranks a software write in the same cycle
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         stateReg <= MSEE_STATE_RST;
      end else if (kindNow != MSEE_K_NONE) begin
         // gate and both translate bits clear on entry
         stateReg <= (stateReg & ~MSEE_CLEAR_MASK & MSEE_STATE_MASK);
      end else if (retReq) begin
         // restore copied bits from the save copy, keep the rest
         stateReg <= (stateReg & ~MSEE_COPY_MASK) | (savedReg & MSEE_COPY_MASK);
      end else if (wrEn && msee_hit(paddr, MSEE_OFF_STATE)) begin
         stateReg <= pwdata & MSEE_STATE_MASK;
      end
   end

   // ---------------------------------------------------------------
   // save copy
   // ---------------------------------------------------------------
   // written in the taking cycle, so it is valid before any handler fetch
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         savedReg <= 32'h0000_0000;
      end else if (kindNow != MSEE_K_NONE) begin
         savedReg <= (stateReg & MSEE_COPY_MASK)
                   | (infoReg & MSEE_INFO_MASK);
      end else if (wrEn && msee_hit(paddr, MSEE_OFF_SAVED)) begin
         savedReg <= pwdata;
      end
   end

   // ---------------------------------------------------------------
   // software registers
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         implReg   <= MSEE_IMPL_RST;
         infoReg   <= 32'h0000_0000;
         offsetReg <= 20'h0_0000;
      end else if (wrEn) begin
         if (msee_hit(paddr, MSEE_OFF_IMPL)) begin
            implReg <= pwdata;
         end
         if (msee_hit(paddr, MSEE_OFF_INFO)) begin
            infoReg <= pwdata & MSEE_INFO_MASK;
         end
         if (msee_hit(paddr, MSEE_OFF_OFFSET)) begin
            offsetReg <= pwdata[19:0];
         end
      end
   end

   // software events are single pulses, cleared the cycle after
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         swEventReg <= '0;
      end else if (wrEn && msee_hit(paddr, MSEE_OFF_EVENT)) begin
         swEventReg <= pwdata[MSEE_EV_NUM-1:0];
      end else begin
         swEventReg <= '0;
      end
   end

   // ---------------------------------------------------------------
   // taken report
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         takeReg <= '0;
      end else begin
         takeReg.taken <= (kindNow != MSEE_K_NONE);
         takeReg.kind  <= kindNow;
         takeReg.vector <= {(stateReg[MSEE_B_IP] ? MSEE_VEC_HIGH : MSEE_VEC_LOW),
                            offsetReg};
      end
   end
   assign takeOut = takeReg;

   // ---------------------------------------------------------------
   // read data
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         prdataReg <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         // captured in setup so data is stable through the access phase
         unique case (1'b1)
            msee_hit(paddr, MSEE_OFF_STATE):  prdataReg <= stateReg;
            msee_hit(paddr, MSEE_OFF_SAVED):  prdataReg <= savedReg;
            msee_hit(paddr, MSEE_OFF_IMPL):   prdataReg <= implReg;
            msee_hit(paddr, MSEE_OFF_STATUS): prdataReg <= {28'h000_0000, fpxReg,
                                                            traceReg, stopReg,
                                                            takeReg.taken};
            msee_hit(paddr, MSEE_OFF_INFO):   prdataReg <= infoReg;
            msee_hit(paddr, MSEE_OFF_OFFSET): prdataReg <= {12'h000, offsetReg};
            default:                          prdataReg <= 32'h0000_0000;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // state outputs
   // ---------------------------------------------------------------
   assign userOnly     = stateReg[MSEE_B_PR];
   assign floatBlocked = !stateReg[MSEE_B_FP] && retire.isFloat;
   assign fetchXlate   = stateReg[MSEE_B_IR];
   assign dataXlate    = stateReg[MSEE_B_DR];
   assign littleEndian = stateReg[MSEE_B_LE];
   assign checkstop    = stopReg;
endmodule

// File: rtl/msee_pkg.sv
// package of constants and types for the machine state exception enable block
package msee_pkg;
   // apb register byte offsets
   localparam logic [11:0] MSEE_OFF_STATE   = 12'h000;  // machine_state_word
   localparam logic [11:0] MSEE_OFF_SAVED   = 12'h004;  // saved_state_copy
   localparam logic [11:0] MSEE_OFF_IMPL    = 12'h008;  // implementation_control
   localparam logic [11:0] MSEE_OFF_STATUS  = 12'h00C;  // sequencer status
   localparam logic [11:0] MSEE_OFF_EVENT   = 12'h010;  // event request, reads as zero
   localparam logic [11:0] MSEE_OFF_RETURN  = 12'h014;  // return from handler
   localparam logic [11:0] MSEE_OFF_INFO    = 12'h018;  // exception-specific srr bits
   localparam logic [11:0] MSEE_OFF_OFFSET  = 12'h01C;  // vector offset selection

   // field positions (big-endian bit numbers mapped to [31-n])
   localparam int MSEE_B_EE  = 31 - 16;
   localparam int MSEE_B_PR  = 31 - 17;
   localparam int MSEE_B_FP  = 31 - 18;
   localparam int MSEE_B_ME  = 31 - 19;
   localparam int MSEE_B_FE0 = 31 - 20;
   localparam int MSEE_B_SE  = 31 - 21;
   localparam int MSEE_B_BE  = 31 - 22;
   localparam int MSEE_B_FE1 = 31 - 23;
   localparam int MSEE_B_IP  = 31 - 25;
   localparam int MSEE_B_IR  = 31 - 26;
   localparam int MSEE_B_DR  = 31 - 27;
   localparam int MSEE_B_RI  = 31 - 30;
   localparam int MSEE_B_LE  = 31 - 31;

   // state bits that are stored: bit 0, 5-9, 13-31 (big-endian numbering)
   localparam logic [31:0] MSEE_STATE_MASK = 32'h87C7_FFFF;
   // bits copied into the save copy on an exception: 5-9 and 16-31
   localparam logic [31:0] MSEE_COPY_MASK  = 32'h07C0_FFFF;
   // exception-specific save bits: 1-4 and 10-15
   localparam logic [31:0] MSEE_INFO_MASK  = 32'h783F_0000;
   // bits forced to zero on every exception: ee pr fp fe0 se be fe1 ir dr ri, 13 14
   localparam logic [31:0] MSEE_CLEAR_MASK = 32'h0006_EF32;
   localparam logic [31:0] MSEE_STATE_RST  = 32'h0000_0040;  // vector prefix high at reset
   localparam logic [31:0] MSEE_IMPL_RST   = 32'h0000_0000;

   localparam logic [11:0] MSEE_VEC_LOW    = 12'h000;  // vector high bits, prefix clear
   localparam logic [11:0] MSEE_VEC_HIGH   = 12'hFFF;  // vector high bits, prefix set
   localparam int          MSEE_NUM_MC     = 4;        // machine check sources

   // event bit positions in the event register
   localparam int MSEE_EV_RESET = 0;
   localparam int MSEE_EV_MCHK  = 1;
   localparam int MSEE_EV_EXT   = 2;
   localparam int MSEE_EV_SMI   = 3;
   localparam int MSEE_EV_DEC   = 4;
   localparam int MSEE_EV_FPX   = 5;
   localparam int MSEE_EV_NUM   = 6;

   typedef enum logic [2:0] {
      MSEE_K_NONE, MSEE_K_RESET, MSEE_K_MCHK, MSEE_K_EXT,
      MSEE_K_SMI, MSEE_K_DEC, MSEE_K_PROG, MSEE_K_TRACE
   } msee_kind_e;

   // instruction completion report from the pipeline
   typedef struct packed {
      logic valid;     // an instruction completed successfully
      logic isBranch;  // it was a branch
      logic isFloat;   // it is a floating-point instruction
   } msee_retire_s;

   // exception-taken report towards the sequencer
   typedef struct packed {
      logic        taken;   // one-cycle pulse
      msee_kind_e  kind;    // which exception
      logic [31:0] vector;  // handler fetch address
   } msee_take_s;
endpackage

// File: verif/msee_unit_asserts.sv
// port-level checker for the machine state exception block
`timescale 1ns/1ps
module msee_unit_asserts
   import msee_pkg::*;
(
   input wire logic                   sys_clk,
   input wire logic                   rst_b,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [11:0]            paddr,
   input wire logic [31:0]            pwdata,
   input wire logic                   pready,
   input wire logic [31:0]            prdata,
   input wire logic                   pslverr,
   input wire logic                   resetReq,
   input wire logic [MSEE_NUM_MC-1:0] machineCheckReq,
   input wire logic                   externalReq,
   input wire logic                   sysMgmtReq,
   input wire logic                   decrementerReq,
   input wire logic                   floatExcReq,
   input wire msee_retire_s           retire,
   input wire msee_take_s             takeOut,
   input wire logic                   userOnly,
   input wire logic                   floatBlocked,
   input wire logic                   fetchXlate,
   input wire logic                   dataXlate,
   input wire logic                   littleEndian,
   input wire logic                   checkstop
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // ----------------------------------------
   // sequences
   // ----------------------------------------
   // a completed apb write to the state word
   sequence s_wr_state;
      psel && penable && pwrite && paddr == MSEE_OFF_STATE;
   endsequence
   // a taken report of one kind
   sequence s_take(msee_kind_e k);
      takeOut.taken && takeOut.kind == k;
   endsequence
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   // an exception decided at the write edge wins, so a take excuses the level
   a_user_level: assert property (s_wr_state |=>
      takeOut.taken || userOnly == $past(pwdata[MSEE_B_PR])) else $error("privilege level wrong");
   a_xlate_write: assert property (s_wr_state |=> takeOut.taken ||
      (fetchXlate == $past(pwdata[MSEE_B_IR]) && dataXlate == $past(pwdata[MSEE_B_DR])))
      else $error("translate enables wrong");
   a_order_write: assert property (s_wr_state |=>
      takeOut.taken || littleEndian == $past(pwdata[MSEE_B_LE])) else $error("byte order wrong");
   a_take_clears: assert property (takeOut.taken |-> !fetchXlate && !dataXlate && !userOnly)
      else $error("state not cleared on take");
   a_float_block: assert property (s_wr_state ##1 (retire.isFloat && !takeOut.taken)
      |-> floatBlocked == !$past(pwdata[MSEE_B_FP])) else $error("float dispatch not blocked");
   a_vector_base: assert property (s_wr_state ##1 !takeOut.taken ##1 takeOut.taken |->
      takeOut.vector[31:20] == ($past(pwdata[MSEE_B_IP], 2) ? MSEE_VEC_HIGH : MSEE_VEC_LOW))
      else $error("vector base wrong");
   a_reset_taken: assert property ($rose(resetReq) && !checkstop |->
      ##[1:2] s_take(MSEE_K_RESET)) else $error("system reset not taken");
   a_gate_cleared: assert property (takeOut.taken |=> !(takeOut.taken &&
      takeOut.kind inside {MSEE_K_EXT, MSEE_K_SMI, MSEE_K_DEC})) else $error("gate not cleared");
   a_stop_sticky: assert property (checkstop |=> checkstop)
      else $error("checkstop released");
   a_stop_quiet: assert property (checkstop && $past(checkstop) |-> !takeOut.taken)
      else $error("take during checkstop");
endmodule
bind msee_unit msee_unit_asserts u_chk (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .prdata(prdata), .pslverr(pslverr), .resetReq(resetReq), .machineCheckReq(machineCheckReq),
   .externalReq(externalReq), .sysMgmtReq(sysMgmtReq), .decrementerReq(decrementerReq),
   .floatExcReq(floatExcReq), .retire(retire), .takeOut(takeOut), .userOnly(userOnly),
   .floatBlocked(floatBlocked), .fetchXlate(fetchXlate), .dataXlate(dataXlate),
   .littleEndian(littleEndian), .checkstop(checkstop));

// File: verif/testbench.sv
// self-checking bench for the machine state exception block
`timescale 1ns/1ps
module testbench
   import msee_pkg::*;
;
   // ----------------------------------------
   // signals and scoreboard
   // ----------------------------------------
   localparam logic [31:0] IPB = 32'h0000_0040, EEB = 32'h0000_8000, SEB = 32'h0000_0400;
   localparam logic [31:0] BEB = 32'h0000_0200, FPB = 32'h0000_2000, MEB = 32'h0000_1000;
   localparam logic [31:0] FE0B = 32'h0000_0800, FE1B = 32'h0000_0100;
   logic                   sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, checkstop;
   logic [11:0]            paddr;
   logic [31:0]            pwdata, prdata, v, info, off;
   logic                   resetReq, floatExcReq, userOnly, floatBlocked;
   logic                   fetchXlate, dataXlate, littleEndian;
   logic [2:0]             asyncReq;   // {decrementer, system management, external}
   logic [MSEE_NUM_MC-1:0] mcReq;      // machine check sources
   msee_retire_s           retire;
   msee_take_s             takeOut;
   logic [32:0]            rdQ[$];     // expected {error, data} per read
   logic [34:0]            tkQ[$];     // expected {kind, vector} per take
   int                     miscompares = 0, n_compared = 0;
   logic [31:0]            rng = 32'h0fa6_58cf;

   msee_unit u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .resetReq(resetReq), .machineCheckReq(mcReq),
      .externalReq(asyncReq[0]), .sysMgmtReq(asyncReq[1]), .decrementerReq(asyncReq[2]),
      .floatExcReq(floatExcReq), .retire(retire), .takeOut(takeOut), .userOnly(userOnly),
      .floatBlocked(floatBlocked), .fetchXlate(fetchXlate), .dataXlate(dataXlate),
      .littleEndian(littleEndian), .checkstop(checkstop));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // fixed-seed xorshift so runs repeat exactly
   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   // one comparison, counted
   task chk(input string nm, input logic [34:0] ex, input logic [34:0] got);
      n_compared++;
      if (got !== ex) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, ex, got);
      end
   endtask
   // apb transfer: request held until pready is seen high with penable
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [11:0] a, input logic [32:0] ex);
      rdQ.push_back(ex);
      apb(1'b0, a, 32'h0000_0000);
   endtask
   // note an expected take; vector base follows the prefix bit
   task expTake(input msee_kind_e k, input logic ip);
      tkQ.push_back({k, ip ? MSEE_VEC_HIGH : MSEE_VEC_LOW, off[19:0]});
   endtask
   // wait for every noted take, then leave room for stray ones to show
   task done();
      repeat (20) if (tkQ.size() != 0) @(posedge sys_clk);
      if (tkQ.size() != 0) begin
         miscompares++;
         $display("Error take_count expected 0 seen %0d", tkQ.size());
      end
      repeat (4) @(posedge sys_clk);
   endtask
   task close_out();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ----------------------------------------
   // clock, watchdog and monitor
   // ----------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // the whole run is a few hundred cycles; this bound is generous
   initial begin
      #80000;
      miscompares++;
      close_out();
   end
   // results are compared where they appear, oldest note first
   always @(posedge sys_clk) begin
      if (psel && penable && pready && !pwrite) begin
         chk("read", rdQ.size() ? {2'b00, rdQ.pop_front()} : 'x, {2'b00, pslverr, prdata});
      end
      if (takeOut.taken === 1'b1) begin
         chk("take", tkQ.size() ? tkQ.pop_front() : 'x, {takeOut.kind, takeOut.vector});
      end
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
      {resetReq, floatExcReq, asyncReq, mcReq} = '0;
      retire = msee_retire_s'(3'b001);  // float flag only, never a completion
      off = xs() & 32'h000F_FFFF;
      repeat (6) @(posedge sys_clk);
      rst_b <= 1'b1;
      rd(MSEE_OFF_STATE, {1'b0, MSEE_STATE_RST});
      rd(MSEE_OFF_IMPL, {1'b0, MSEE_IMPL_RST});
      rd(12'h020, {1'b1, 32'h0000_0000});  // unmapped place
      wr(MSEE_OFF_OFFSET, off);
      // random state words: stored bits and the levels they drive
      for (int i = 0; i < 8; i++) begin
         v = xs();
         wr(MSEE_OFF_STATE, v);
         rd(MSEE_OFF_STATE, {1'b0, v & MSEE_STATE_MASK});
         chk("levels", {v[MSEE_B_PR], v[MSEE_B_IR], v[MSEE_B_DR], v[MSEE_B_LE], ~v[MSEE_B_FP]},
            {userOnly, fetchXlate, dataXlate, littleEndian, floatBlocked});
      end
      retire <= '0;
      // maskable requests wait for the gate, then are taken once
      for (int i = 0; i < 3; i++) begin
         wr(MSEE_OFF_STATE, 32'h0000_0000);
         asyncReq <= 3'b001 << i;
         repeat (6) @(posedge sys_clk);
         expTake(msee_kind_e'(MSEE_K_EXT + i), i[0]);
         wr(MSEE_OFF_STATE, EEB | (i[0] ? IPB : 32'h0000_0000));
         done();
         asyncReq <= 3'b000;
      end
      // reset request with every gate closed
      expTake(MSEE_K_RESET, 1'b0);
      resetReq <= 1'b1;
      @(posedge sys_clk);
      resetReq <= 1'b0;
      done();
      // branch trace, then the saved copy and the cleared state
      info = xs();
      wr(MSEE_OFF_INFO, info);
      v = (xs() & MSEE_STATE_MASK & ~(EEB | SEB | MEB)) | BEB | IPB;
      wr(MSEE_OFF_STATE, v);
      for (int b = 0; b < 2; b++) begin
         if (b == 1) expTake(MSEE_K_TRACE, 1'b1);
         @(posedge sys_clk);
         retire <= msee_retire_s'({1'b1, b[0], 1'b0});
         @(posedge sys_clk);
         retire <= '0;
         done();
      end
      rd(MSEE_OFF_SAVED, {1'b0, (v & MSEE_COPY_MASK) | (info & MSEE_INFO_MASK)});
      rd(MSEE_OFF_STATE, {1'b0, v & ~MSEE_CLEAR_MASK});
      wr(MSEE_OFF_RETURN, 32'h0000_0000);
      rd(MSEE_OFF_STATE, {1'b0, (v & ~MSEE_CLEAR_MASK) | (v & MSEE_COPY_MASK)});
      // single step traps on a plain completion
      wr(MSEE_OFF_STATE, SEB | IPB);
      expTake(MSEE_K_TRACE, 1'b1);
      @(posedge sys_clk);
      retire <= msee_retire_s'(3'b100);
      @(posedge sys_clk);
      retire <= '0;
      done();
      // float exception in each mode; mode zero ignores it
      for (int m = 0; m < 4; m++) begin
         wr(MSEE_OFF_STATE, FPB | IPB | (m[0] ? FE0B : '0) | (m[1] ? FE1B : '0));
         if (m != 0) expTake(MSEE_K_PROG, 1'b1);
         floatExcReq <= 1'b1;
         @(posedge sys_clk);
         floatExcReq <= 1'b0;
         done();
      end
      // machine checks: disabled source, enabled source, then gate closed
      wr(MSEE_OFF_IMPL, 32'h0000_0001);
      for (int s = 0; s < 3; s++) begin
         wr(MSEE_OFF_STATE, (s == 2 ? '0 : MEB) | IPB);
         if (s == 1) expTake(MSEE_K_MCHK, 1'b1);
         mcReq <= (s == 0) ? 4'h2 : 4'h1;
         @(posedge sys_clk);
         mcReq <= 4'h0;
         done();
      end
      chk("checkstop", 35'h1, {34'h0, checkstop});
      resetReq <= 1'b1;  // nothing is taken once stopped
      done();
      close_out();
   end
endmodule
